// *** pkg/ifec_cfg.svh ***
`ifndef IFEC_CFG_SVH
`define IFEC_CFG_SVH
// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define IFEC_IDX_EDGE 4'h0
`define IFEC_IDX_PIC0 4'h1
`define IFEC_IDX_PIC1 4'h2
`define IFEC_IDX_PIC2 4'h3
`define IFEC_IDX_PIC3 4'h4
`define IFEC_IDX_MFC0 4'h5
`define IFEC_IDX_MFC1 4'h6
`define IFEC_IDX_MFC2 4'h7
`define IFEC_IDX_MFC3 4'h8
// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define IFEC_RST_BYTE 8'h00
`define IFEC_EDGE_LO_MASK 8'h0f
// primary_int_ctrl_0 bit positions
`define IFEC_GIE_BIT 0
`define IFEC_P0_EN_BIT 1
`define IFEC_P1_EN_BIT 2
`define IFEC_P0_FLAG_BIT 4
`define IFEC_P1_FLAG_BIT 5
`define IFEC_PIC0_MASK 8'h7f
// primary_int_ctrl_1/2 multi-function pair positions
`define IFEC_MF0_EN_BIT 1
`define IFEC_MF0_FLAG_BIT 5
`define IFEC_MF1_EN_BIT 2
`define IFEC_MF1_FLAG_BIT 6
`define IFEC_MF2_EN_BIT 0
`define IFEC_MF2_FLAG_BIT 4
`define IFEC_MF3_EN_BIT 3
`define IFEC_MF3_FLAG_BIT 7
// primary_int_ctrl_3 positions (pins 2 and 3)
`define IFEC_P2_EN_BIT 0
`define IFEC_P3_EN_BIT 1
`define IFEC_P2_FLAG_BIT 4
`define IFEC_P3_FLAG_BIT 5
`define IFEC_PIC3_MASK 8'h33
// comparator, converter and time base pair positions
`define IFEC_CMP0_EN_BIT 3
`define IFEC_CMP0_FLAG_BIT 6
`define IFEC_CMP1_EN_BIT 0
`define IFEC_CMP1_FLAG_BIT 4
`define IFEC_ADC_EN_BIT 3
`define IFEC_ADC_FLAG_BIT 7
`define IFEC_TB0_EN_BIT 1
`define IFEC_TB0_FLAG_BIT 5
`define IFEC_TB1_EN_BIT 2
`define IFEC_TB1_FLAG_BIT 6
// multi-function register fields
`define IFEC_MFC_FLAGS 7:4
`define IFEC_MFC_ENS 3:0
// synchroniser fill marker after reset
`define IFEC_FILL_RST 3'h0
`define IFEC_FILL_DONE 2
// multi-function registers: flags in high nibble, enables in low
`define IFEC_MFC_MASK 8'hff
`endif

// *** pkg/ifec_pkg.sv ***
package ifec_pkg;
	typedef logic [7:0] ifec_byte_type;
	typedef logic [3:0] ifec_addr_type;
	typedef enum logic [1:0] {
		ifec_edge_off,
		ifec_edge_rise,
		ifec_edge_fall,
		ifec_edge_both
	} ifec_edge_type;
endpackage

// *** verilog/ifec_ctrl.sv ***
`timescale 1ns/1ps
`include "ifec_cfg.svh"
// Functional notes
// - edge register bits 1..0 pick pin 0 edge: off, rise, fall, both.
// - edge register bits 3..2 pick pin 1 edge, same encoding.
// - four-pin variant: bits 5..4 pick pin 2 edge, same encoding.
// - four-pin variant: bits 7..6 pick pin 3 edge, same encoding.
// - two-pin variant reads bits 7..4 as zero; edge fields reset zero.
// - hardware sets request flags on events; software sets enables.
// - every source has its own enable bit and request flag.
// - peripheral sources grouped in multi-function regs feeding one pair.
module ifec_ctrl #(
	parameter int FOUR_PINS = 1,
	parameter int MF_SRC = 4
) (
	clk,
	reset,
	reg_addr,
	reg_wr,
	reg_wdata,
	reg_rdata,
	ext_pin,
	cmp_evt,
	adc_evt,
	tbase_evt,
	mf_evt,
	irq_req
);
	import ifec_pkg::*;
	input wire logic clk;
	input wire logic reset;
	input wire ifec_pkg::ifec_addr_type reg_addr;
	input wire logic reg_wr;
	input wire ifec_pkg::ifec_byte_type reg_wdata;
	output ifec_pkg::ifec_byte_type reg_rdata;
	input wire logic [3:0] ext_pin;
	input wire logic [1:0] cmp_evt;
	input wire logic adc_evt;
	input wire logic [1:0] tbase_evt;
	input wire logic [4*MF_SRC-1:0] mf_evt;
	output logic irq_req;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ifec_byte_type edge_ff, nxt_edge;
	ifec_byte_type pic_ff [4];
	ifec_byte_type nxt_pic [4];
	ifec_byte_type mfc_ff [4];
	ifec_byte_type nxt_mfc [4];
	logic [3:0] sync1_ff, sync2_ff, prev_ff;
	logic [2:0] fill_ff, nxt_fill;
	ifec_byte_type rdata_ff, nxt_rdata;
	logic irq_ff, nxt_irq;
	logic [3:0] pin_hit;
	logic [3:0] mf_any;
	logic [3:0] pin_en, pin_flag;

	// ----------------------------------------------------------------
	// pin edge detection
	// ----------------------------------------------------------------
	// edge detection per pin from the selected field
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			case (ifec_edge_type'(edge_ff[2*i +: 2]))
				ifec_edge_rise: pin_hit[i] = sync2_ff[i] & ~prev_ff[i];
				ifec_edge_fall: pin_hit[i] = ~sync2_ff[i] & prev_ff[i];
				ifec_edge_both: pin_hit[i] = sync2_ff[i] ^ prev_ff[i];
				default: pin_hit[i] = 1'b0;
			endcase
		end
		// chain not yet filled after reset: a high pin is no edge
		if (!fill_ff[`IFEC_FILL_DONE]) pin_hit = 4'h0;
	end

	// fill marker, ones shift in behind the pin chain
	always_comb begin
		nxt_fill = {fill_ff[1:0], 1'b1};
	end

	// a multi-function group is pending when any enabled source flag is set
	always_comb begin
		for (int m = 0; m < 4; m++) begin
			mf_any[m] = |(mfc_ff[m][`IFEC_MFC_FLAGS] &
				mfc_ff[m][`IFEC_MFC_ENS]);
		end
	end

	// ----------------------------------------------------------------
	// register update
	// ----------------------------------------------------------------
	// next values of all control registers
	always_comb begin
		logic [3:0] mfs;
		mfs = 4'h0;
		nxt_edge = edge_ff;
		nxt_pic = pic_ff;
		nxt_mfc = mfc_ff;
		// software writes: enables and flags both writable
		if (reg_wr) begin
			case (reg_addr)
				`IFEC_IDX_EDGE: nxt_edge = (FOUR_PINS != 0) ? reg_wdata :
					(reg_wdata & `IFEC_EDGE_LO_MASK);
				`IFEC_IDX_PIC0: nxt_pic[0] = reg_wdata & `IFEC_PIC0_MASK;
				`IFEC_IDX_PIC1: nxt_pic[1] = reg_wdata;
				`IFEC_IDX_PIC2: nxt_pic[2] = reg_wdata;
				`IFEC_IDX_PIC3: nxt_pic[3] = (FOUR_PINS != 0) ?
					(reg_wdata & `IFEC_PIC3_MASK) : `IFEC_RST_BYTE;
				`IFEC_IDX_MFC0: nxt_mfc[0] = reg_wdata & `IFEC_MFC_MASK;
				`IFEC_IDX_MFC1: nxt_mfc[1] = reg_wdata & `IFEC_MFC_MASK;
				`IFEC_IDX_MFC2: nxt_mfc[2] = reg_wdata & `IFEC_MFC_MASK;
				`IFEC_IDX_MFC3: nxt_mfc[3] = reg_wdata & `IFEC_MFC_MASK;
				default: ;
			endcase
		end
		// hardware sets win over a same-cycle software clear
		for (int m = 0; m < 4; m++) begin
			mfs = mf_evt[4*m +: 4];
			nxt_mfc[m][`IFEC_MFC_FLAGS] = nxt_mfc[m][`IFEC_MFC_FLAGS] |
				mfs;
		end
		if (pin_hit[0]) nxt_pic[0][`IFEC_P0_FLAG_BIT] = 1'b1;
		if (pin_hit[1]) nxt_pic[0][`IFEC_P1_FLAG_BIT] = 1'b1;
		if (cmp_evt[0]) nxt_pic[0][`IFEC_CMP0_FLAG_BIT] = 1'b1;
		if (cmp_evt[1]) nxt_pic[1][`IFEC_CMP1_FLAG_BIT] = 1'b1;
		if (adc_evt) nxt_pic[1][`IFEC_ADC_FLAG_BIT] = 1'b1;
		if (tbase_evt[0]) nxt_pic[2][`IFEC_TB0_FLAG_BIT] = 1'b1;
		if (tbase_evt[1]) nxt_pic[2][`IFEC_TB1_FLAG_BIT] = 1'b1;
		if (mf_any[0]) nxt_pic[1][`IFEC_MF0_FLAG_BIT] = 1'b1;
		if (mf_any[1]) nxt_pic[1][`IFEC_MF1_FLAG_BIT] = 1'b1;
		if (mf_any[2]) nxt_pic[2][`IFEC_MF2_FLAG_BIT] = 1'b1;
		if (mf_any[3]) nxt_pic[2][`IFEC_MF3_FLAG_BIT] = 1'b1;
		if (FOUR_PINS != 0) begin
			if (pin_hit[2]) nxt_pic[3][`IFEC_P2_FLAG_BIT] = 1'b1;
			if (pin_hit[3]) nxt_pic[3][`IFEC_P3_FLAG_BIT] = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// request and read-back
	// ----------------------------------------------------------------
	// pin enables and flags gathered per pin
	always_comb begin
		pin_en = {pic_ff[3][`IFEC_P3_EN_BIT], pic_ff[3][`IFEC_P2_EN_BIT],
			pic_ff[0][`IFEC_P1_EN_BIT], pic_ff[0][`IFEC_P0_EN_BIT]};
		pin_flag = {pic_ff[3][`IFEC_P3_FLAG_BIT],
			pic_ff[3][`IFEC_P2_FLAG_BIT],
			pic_ff[0][`IFEC_P1_FLAG_BIT], pic_ff[0][`IFEC_P0_FLAG_BIT]};
	end

	// request to core: any flag with its enable, gated by global enable
	always_comb begin
		nxt_irq = pic_ff[0][`IFEC_GIE_BIT] & (
			(|(pin_en & pin_flag)) |
			(pic_ff[0][`IFEC_CMP0_EN_BIT] & pic_ff[0][`IFEC_CMP0_FLAG_BIT]) |
			(pic_ff[1][`IFEC_CMP1_EN_BIT] & pic_ff[1][`IFEC_CMP1_FLAG_BIT]) |
			(pic_ff[1][`IFEC_ADC_EN_BIT] & pic_ff[1][`IFEC_ADC_FLAG_BIT]) |
			(pic_ff[1][`IFEC_MF0_EN_BIT] & pic_ff[1][`IFEC_MF0_FLAG_BIT]) |
			(pic_ff[1][`IFEC_MF1_EN_BIT] & pic_ff[1][`IFEC_MF1_FLAG_BIT]) |
			(pic_ff[2][`IFEC_MF2_EN_BIT] & pic_ff[2][`IFEC_MF2_FLAG_BIT]) |
			(pic_ff[2][`IFEC_MF3_EN_BIT] & pic_ff[2][`IFEC_MF3_FLAG_BIT]) |
			(pic_ff[2][`IFEC_TB0_EN_BIT] & pic_ff[2][`IFEC_TB0_FLAG_BIT]) |
			(pic_ff[2][`IFEC_TB1_EN_BIT] & pic_ff[2][`IFEC_TB1_FLAG_BIT]));
	end

	// registered read data
	always_comb begin
		case (reg_addr)
			`IFEC_IDX_EDGE: nxt_rdata = edge_ff;
			`IFEC_IDX_PIC0: nxt_rdata = pic_ff[0];
			`IFEC_IDX_PIC1: nxt_rdata = pic_ff[1];
			`IFEC_IDX_PIC2: nxt_rdata = pic_ff[2];
			`IFEC_IDX_PIC3: nxt_rdata = pic_ff[3];
			`IFEC_IDX_MFC0: nxt_rdata = mfc_ff[0];
			`IFEC_IDX_MFC1: nxt_rdata = mfc_ff[1];
			`IFEC_IDX_MFC2: nxt_rdata = mfc_ff[2];
			`IFEC_IDX_MFC3: nxt_rdata = mfc_ff[3];
			default: nxt_rdata = `IFEC_RST_BYTE;
		endcase
	end

	// ----------------------------------------------------------------
	// flip-flops
	// ----------------------------------------------------------------
	// control registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			edge_ff <= `IFEC_RST_BYTE;
			for (int k = 0; k < 4; k++) begin
				pic_ff[k] <= `IFEC_RST_BYTE;
				mfc_ff[k] <= `IFEC_RST_BYTE;
			end
		end else begin
			edge_ff <= nxt_edge;
			pic_ff <= nxt_pic;
			mfc_ff <= nxt_mfc;
		end
	end

	// pin synchroniser, edge history and fill marker
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync1_ff <= 4'h0;
			sync2_ff <= 4'h0;
			prev_ff <= 4'h0;
			fill_ff <= `IFEC_FILL_RST;
		end else begin
			sync1_ff <= ext_pin;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
			fill_ff <= nxt_fill;
		end
	end

	// registered outputs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata_ff <= `IFEC_RST_BYTE;
			irq_ff <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			irq_ff <= nxt_irq;
		end
	end

	assign reg_rdata = rdata_ff;
	assign irq_req = irq_ff;
endmodule

// *** test/ifec_chk.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module ifec_chk #(
	parameter int FOUR_PINS = 1,
	parameter int MF_SRC = 4
) (
	input wire logic clk,
	input wire logic reset,
	input wire ifec_pkg::ifec_addr_type reg_addr,
	input wire logic reg_wr,
	input wire ifec_pkg::ifec_byte_type reg_wdata,
	input wire ifec_pkg::ifec_byte_type reg_rdata,
	input wire logic [3:0] ext_pin,
	input wire logic [1:0] cmp_evt,
	input wire logic adc_evt,
	input wire logic [1:0] tbase_evt,
	input wire logic [4*MF_SRC-1:0] mf_evt,
	input wire logic irq_req
);
	import ifec_pkg::*;
	localparam ifec_byte_type EMASK = FOUR_PINS ? 8'hff : 8'h0f;
	localparam ifec_byte_type P3ZERO = FOUR_PINS ? 8'hcc : 8'hff;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_rst; $fell(reset) |-> reg_rdata == 8'h00 && !irq_req; endproperty
	a_rst: assert property (p_rst) else $error("reset value");
	property p_edge; reg_wr && reg_addr == 4'h0 ##1 reg_addr == 4'h0
		|=> reg_rdata == ($past(reg_wdata, 2) & EMASK); endproperty
	a_edge: assert property (p_edge) else $error("edge");
	property p_hold; !reg_wr && reg_addr == 4'h0 ##1 reg_addr == 4'h0
		|=> $stable(reg_rdata); endproperty
	a_hold: assert property (p_hold) else $error("edge drift");
	property p_unmap; reg_addr > 4'h8 |=> reg_rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped");
	property p_pic0; reg_addr == 4'h1 |=> !reg_rdata[7]; endproperty
	a_pic0: assert property (p_pic0) else $error("pic0 bit7");
	property p_pic3; reg_addr == 4'h4 |=> (reg_rdata & P3ZERO) == 8'h00;
	endproperty
	a_pic3: assert property (p_pic3) else $error("pic3 mask");
	property p_gie; reg_wr && reg_addr == 4'h1 && !reg_wdata[0]
		|-> ##2 !irq_req; endproperty
	a_gie: assert property (p_gie) else $error("global off");
	property p_en; reg_wr && reg_addr == 4'h2 ##1 reg_addr == 4'h2
		|=> (reg_rdata & 8'h0f) == ($past(reg_wdata, 2) & 8'h0f); endproperty
	a_en: assert property (p_en) else $error("enables");
endmodule
bind ifec_ctrl ifec_chk #(.FOUR_PINS(FOUR_PINS), .MF_SRC(MF_SRC)) chk (
	.clk(clk),
	.reset(reset),
	.reg_addr(reg_addr),
	.reg_wr(reg_wr),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.ext_pin(ext_pin),
	.cmp_evt(cmp_evt),
	.adc_evt(adc_evt),
	.tbase_evt(tbase_evt),
	.mf_evt(mf_evt),
	.irq_req(irq_req)
);

// *** test/ifec_src.sv ***
`timescale 1ns/1ps
// peripheral event sources: one pulse per requested cycle
module ifec_src (
	input wire logic clk,
	input wire logic reset,
	input wire logic [20:0] fire_vec,
	output logic [20:0] evt_vec
);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			evt_vec <= 21'h000000;
		end else begin
			evt_vec <= fire_vec;
		end
	end
endmodule

// *** test/test_interrupt_flag_enable_edge_ctrl.sv ***
`timescale 1ns/1ps
module test_interrupt_flag_enable_edge_ctrl;
	import ifec_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	ifec_addr_type reg_addr = 4'h0;
	logic reg_wr = 1'b0;
	ifec_byte_type reg_wdata = 8'h00;
	ifec_byte_type reg_rdata, rdata2, exp1, exp2;
	ifec_addr_type fa;
	logic [3:0] ext_pin = 4'h0;
	logic [1:0] cmp_evt, tbase_evt;
	logic adc_evt, irq_req;
	logic [15:0] mf_evt;
	logic [20:0] fire_vec = 21'h000000;
	logic [20:0] evt_vec;
	int bad_count = 0;
	int n_checks = 0;
	ifec_byte_type msk[10] = '{8'hff, 8'h7f, 8'hff, 8'hff, 8'h33,
		8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
	ifec_byte_type msk2[10] = '{8'h0f, 8'h7f, 8'hff, 8'hff, 8'h00,
		8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
	always #50 clk = ~clk;
	assign {mf_evt, tbase_evt, adc_evt, cmp_evt} = evt_vec;
	ifec_src SRC (.clk(clk), .reset(reset), .fire_vec(fire_vec),
		.evt_vec(evt_vec));
	ifec_ctrl DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.ext_pin(ext_pin), .cmp_evt(cmp_evt), .adc_evt(adc_evt),
		.tbase_evt(tbase_evt), .mf_evt(mf_evt), .irq_req(irq_req));
	ifec_ctrl #(.FOUR_PINS(0)) DUT2 (.clk(clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata(rdata2), .ext_pin(ext_pin), .cmp_evt(cmp_evt),
		.adc_evt(adc_evt), .tbase_evt(tbase_evt), .mf_evt(mf_evt),
		.irq_req());
	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic check(input ifec_byte_type got, input ifec_byte_type e);
		n_checks++;
		if (got !== e) begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, e);
		end
	endtask
	task automatic wr(input ifec_addr_type a, input ifec_byte_type d);
		@(posedge clk);
		#1 reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1 reg_wr = 1'b0;
	endtask
	task automatic rd(input ifec_addr_type a, input ifec_byte_type e,
		input ifec_byte_type e2);
		@(posedge clk);
		#1 reg_addr = a;
		@(posedge clk);
		#1 check(reg_rdata, e);
		check(rdata2, e2);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// watchdog against a hung run
	initial begin
		repeat (6000) @(posedge clk);
		bad_count++;
		complete_run;
	end
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		#1 reset = 1'b0;
		for (int i = 0; i < 10; i++) begin
			rd(i[3:0], 8'h00, 8'h00);
			wr(i[3:0], 8'hff);
			rd(i[3:0], msk[i], msk2[i]);
			wr(i[3:0], 8'h00);
		end
		wr(4'h2, 8'h00);
		wr(4'h3, 8'h00);
		$display("register map test done");
		// every edge code on every pin, rising then falling
		for (int p = 0; p < 4; p++) begin
			fa = p < 2 ? 4'h1 : 4'h4;
			for (int c = 0; c < 4; c++) begin
				wr(4'h0, ifec_byte_type'(c << (2 * p)));
				for (int e = 0; e < 2; e++) begin
					exp1 = c[e] ? 8'h10 << (p % 2) : 8'h00;
					exp2 = p < 2 ? exp1 : 8'h00;
					ext_pin[p] = (e == 0);
					repeat (4) @(posedge clk);
					rd(fa, exp1, exp2);
					wr(fa, 8'h00);
				end
			end
		end
		$display("edge select test done");
		// comparators, converter, time bases and group 0 source 0 fire, grouped source raises a request
		wr(4'h5, 8'h01);
		wr(4'h2, 8'h02);
		wr(4'h1, 8'h01);
		fire_vec = 21'h00003f;
		@(posedge clk);
		#1 fire_vec = 21'h000000;
		repeat (6) @(posedge clk);
		#1 check({7'h00, irq_req}, 8'h01);
		rd(4'h5, 8'h11, 8'h11);
		rd(4'h2, 8'hb2, 8'hb2);
		rd(4'h3, 8'h60, 8'h60);
		rd(4'h1, 8'h41, 8'h41);
		wr(4'h1, 8'h00);
		repeat (2) @(posedge clk);
		#1 check({7'h00, irq_req}, 8'h00);
		$display("event test done");
		// pin 0 request path: no request until its flag is set
		wr(4'h5, 8'h00);
		wr(4'h2, 8'h00);
		wr(4'h0, 8'h01);
		wr(4'h1, 8'h03);
		repeat (2) @(posedge clk);
		#1 check({7'h00, irq_req}, 8'h00);
		ext_pin[0] = 1'b1;
		repeat (6) @(posedge clk);
		#1 check({7'h00, irq_req}, 8'h01);
		rd(4'h1, 8'h13, 8'h13);
		$display("pin request test done");
		complete_run;
	end
endmodule
